// *** rtl/gpio_port.v ***
// one 8-pin general purpose port with analog select, peripheral takeover and open drain
// Notes on behaviour
// - direction bit 0 enables the pin's output driver.
// - direction bit 1 releases the pin to high impedance as input.
// - pin-level read returns 1 for a high input pin, 0 for low.
// - digital input enable set turns on buffer; pin read follows pin.
// - digital input enable clear forces the pin read to 0.
// - reset clears every digital input enable, analog mode.
// - writing the pin-level register writes the output latch.
// - output pin drives the latch value, high for 1, low for 0.
// - latch read returns the latch, never the pin level.
// - an enabled peripheral owns its pin instead of the port logic.
// - a peripheral goes open drain only while its own control bit is set.
// - open drain exists for serial transceivers, SPI ports and PWM modules.
// - open drain follows whichever pin the remap currently assigns.
`timescale 1ns/100ps
`include "gpio_port_defines.vh"
module gpio_port
(
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // processor side writes
  input wire dir_wr_i,
  input wire [`PORT_WIDTH-1:0] dir_wdata_i,
  input wire latch_wr_i,
  input wire port_wr_i,
  input wire [`PORT_WIDTH-1:0] data_wdata_i,
  input wire ansel_wr_i,
  input wire [`ANALOG_PINS-1:0] ansel_wdata_i,
  input wire od_wr_i,
  input wire [1:0] od_sel_i,
  input wire [`ODC_WIDTH-1:0] od_wdata_i,
  // peripheral pin remap, three bits per pin
  input wire [3*`PORT_WIDTH-1:0] peripheral_pin_remap_i,
  // peripheral outputs: uart1 uart2 spi1 spi2 pwm1 pwm2
  input wire [`PERIPH_OUTS-1:0] periph_out_i,
  input wire [`PERIPH_OUTS-1:0] periph_en_i,
  // pads
  input wire [`PORT_WIDTH-1:0] pad_i,
  output reg [`PORT_WIDTH-1:0] pad_o,
  output reg [`PORT_WIDTH-1:0] pad_oe_o,
  // register readback
  output reg [`PORT_WIDTH-1:0] pin_direction_o,
  output reg [`PORT_WIDTH-1:0] output_latch_o,
  output reg [`PORT_WIDTH-1:0] pin_level_o,
  output reg [`ANALOG_PINS-1:0] analog_select_o,
  output reg [3*`ODC_WIDTH-1:0] open_drain_control_o
);

  reg [`PORT_WIDTH-1:0] pin_direction_reg;
  reg [`PORT_WIDTH-1:0] output_latch_reg;
  reg [`ANALOG_PINS-1:0] analog_select_reg;
  reg [`ODC_WIDTH-1:0] od_pwm_reg;
  reg [`ODC_WIDTH-1:0] od_uart_reg;
  reg [`ODC_WIDTH-1:0] od_spi_reg;
  reg [`PORT_WIDTH-1:0] pad_meta_reg;
  reg [`PORT_WIDTH-1:0] pad_sync_reg;
  wire [`PORT_WIDTH-1:0] pad_next;
  wire [`PORT_WIDTH-1:0] pad_oe_next;
  wire [`PORT_WIDTH-1:0] level_next;
  // per source open drain enable, index is remap code minus one
  wire [`PERIPH_OUTS-1:0] src_od;
  // open-drain group strobes
  wire od_pwm_wr;
  wire od_uart_wr;
  wire od_spi_wr;

  // each peripheral has its own open-drain bit, only the listed units get one
  assign src_od[0] = od_uart_reg[`ODC_UART1];
  assign src_od[1] = od_uart_reg[`ODC_UART2];
  assign src_od[2] = od_spi_reg[`ODC_SPI1];
  assign src_od[3] = od_spi_reg[`ODC_SPI2];
  assign src_od[4] = od_pwm_reg[`ODC_PWM1];
  assign src_od[5] = od_pwm_reg[`ODC_PWM2];

  // select code 3 matches no group, so that write is dropped
  assign od_pwm_wr = od_wr_i && (od_sel_i == 2'h0);
  assign od_uart_wr = od_wr_i && (od_sel_i == 2'h1);
  assign od_spi_wr = od_wr_i && (od_sel_i == 2'h2);

  // direction register; reset leaves every pin an input
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
      pin_direction_reg <= `DIR_RESET;
    else if (dir_wr_i)
      pin_direction_reg <= dir_wdata_i;
  end

  // port and latch writes both land in the latch, never on the pins directly
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
      output_latch_reg <= `LATCH_RESET;
    else if (latch_wr_i || port_wr_i)
      output_latch_reg <= data_wdata_i;
  end

  // digital input enables; reset keeps analog pins off the digital buffer
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
      analog_select_reg <= `ANSEL_RESET;
    else if (ansel_wr_i)
      analog_select_reg <= ansel_wdata_i;
  end

  // open-drain bits, one group per strobe
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      od_pwm_reg <= `ODC_RESET;
      od_uart_reg <= `ODC_RESET;
      od_spi_reg <= `ODC_RESET;
    end
    else
    begin
      if (od_pwm_wr)
        od_pwm_reg <= od_wdata_i;
      if (od_uart_wr)
        od_uart_reg <= od_wdata_i;
      if (od_spi_wr)
        od_spi_reg <= od_wdata_i;
    end
  end

  // two-flop synchroniser on the pads; first stage feeds only the second
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pad_meta_reg <= 8'h00;
      pad_sync_reg <= 8'h00;
    end
    else
    begin
      pad_meta_reg <= pad_i;
      pad_sync_reg <= pad_meta_reg;
    end
  end

  // per pin driver and input path
  genvar i;
  generate
    for (i = 0; i < `PORT_WIDTH; i = i + 1)
    begin : pin_g
      wire [2:0] code;
      wire known;
      wire owned;
      wire pval;
      wire pod;
      wire periph_oe;
      assign code = peripheral_pin_remap_i[3*i+2:3*i];
      // code 0 and codes past the last unit leave the pin to the port logic
      assign known = (code != `SRC_NONE) && (code <= `SRC_PWM2);
      // remapped enabled peripheral takes the pin over
      assign owned = known && periph_en_i[code-3'h1];
      assign pval = owned ? periph_out_i[code-3'h1] : 1'b0;
      assign pod = owned ? src_od[code-3'h1] : 1'b0;
      // open drain only pulls low; a released line relies on the outside pull-up
      assign periph_oe = pod ? ~pval : 1'b1;
      // otherwise the direction bit gates the driver
      assign pad_next[i] = owned ? (pod ? 1'b0 : pval) : output_latch_reg[i];
      assign pad_oe_next[i] = owned ? periph_oe : ~pin_direction_reg[i];
      // analog capable pins read 0 while their digital buffer is off
      if (i < `ANALOG_PINS)
      begin : an_g
        assign level_next[i] = analog_select_reg[i] & pad_sync_reg[i];
      end
      else
      begin : dig_g
        assign level_next[i] = pad_sync_reg[i];
      end
    end
  endgenerate

  // pad drivers from flops, so remap changes cannot glitch the pins
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pad_o <= 8'h00;
      pad_oe_o <= 8'h00;
    end
    else
    begin
      pad_o <= pad_next;
      pad_oe_o <= pad_oe_next;
    end
  end

  // readbacks; a one-cycle lag versus control writes, traded for clean outputs
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      pin_direction_o <= `DIR_RESET;
      output_latch_o <= `LATCH_RESET;
      pin_level_o <= 8'h00;
      analog_select_o <= `ANSEL_RESET;
      open_drain_control_o <= 6'h00;
    end
    else
    begin
      pin_direction_o <= pin_direction_reg;
      output_latch_o <= output_latch_reg;
      pin_level_o <= level_next;
      analog_select_o <= analog_select_reg;
      open_drain_control_o <= {od_spi_reg, od_uart_reg, od_pwm_reg};
    end
  end

endmodule

// *** rtl/gpio_port_defines.vh ***
// constants for the general purpose port with open-drain peripherals
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH
`define PORT_WIDTH 8
`define ANALOG_PINS 5
`define PERIPH_OUTS 6
`define ODC_WIDTH 2
`define DIR_RESET 8'hFF
`define LATCH_RESET 8'h00
`define ANSEL_RESET 5'h00
`define ODC_RESET 2'h0
`define ODC_PWM1 0
`define ODC_PWM2 1
`define ODC_UART1 0
`define ODC_UART2 1
`define ODC_SPI1 0
`define ODC_SPI2 1
`define SRC_NONE 3'h0
`define SRC_UART1 3'h1
`define SRC_UART2 3'h2
`define SRC_SPI1 3'h3
`define SRC_SPI2 3'h4
`define SRC_PWM1 3'h5
`define SRC_PWM2 3'h6
`endif

// *** dv/gpio_pins_model.sv ***
// outside circuit on the port pins
`timescale 1ns/100ps
module gpio_pins_model (
  input logic [7:0] pad_o, pad_oe_o, ext_val,
  output logic [7:0] pad_i
);
  // a released pin shows the outside level; pulled-up lines idle at 1
  assign pad_i = pad_oe_o & pad_o | ~pad_oe_o & ext_val;
endmodule

// *** dv/gpio_port_chk.sv ***
// assertions on the port block's pins and readbacks
`timescale 1ns/100ps
module gpio_port_chk (
  input logic mclk_i, rst_n_i, dir_wr_i, latch_wr_i, port_wr_i, ansel_wr_i, od_wr_i,
  input logic [7:0] dir_wdata_i, data_wdata_i, pad_i, pad_o, pad_oe_o, pin_direction_o,
  input logic [7:0] output_latch_o, pin_level_o,
  input logic [4:0] ansel_wdata_i, analog_select_o,
  input logic [1:0] od_sel_i, od_wdata_i,
  input logic [5:0] periph_en_i, open_drain_control_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_dir_load: assert property (dir_wr_i |-> ##2 pin_direction_o == $past(dir_wdata_i, 2)) else $error("dir");
  a_latch_load: assert property (latch_wr_i || port_wr_i |->
    ##2 output_latch_o == $past(data_wdata_i, 2)) else $error("latch");
  a_ansel_load: assert property (ansel_wr_i |->
    ##2 analog_select_o == $past(ansel_wdata_i, 2)) else $error("ansel");
  a_od_load: assert property (od_wr_i && od_sel_i == 2'h0 |->
    ##2 open_drain_control_o[1:0] == $past(od_wdata_i, 2)) else $error("od");
  a_oe_gpio: assert property ($past(periph_en_i) == 6'h00 |-> pad_oe_o == ~pin_direction_o) else $error("oe");
  a_out_latch: assert property ($past(periph_en_i) == 6'h00 |->
    (pad_o & pad_oe_o) == (output_latch_o & pad_oe_o)) else $error("out");
  a_analog_zero: assert property (analog_select_o == 5'h00 [*4] |-> pin_level_o[4:0] == 5'h00) else $error("an");
  a_pin_follow: assert property (($stable(pad_i) && analog_select_o == 5'h1F) [*4] |->
    pin_level_o == pad_i) else $error("pin");
  a_reset_state: assert property ($rose(rst_n_i) |->
    pin_direction_o == 8'hFF && pad_oe_o == 8'h00 && analog_select_o == 5'h00) else $error("rst");
  c_od_drive: cover property (periph_en_i != 6'h00 && pad_oe_o != 8'h00);
  c_od_write: cover property (od_wr_i);
  c_analog: cover property (ansel_wr_i);
endmodule
bind gpio_port gpio_port_chk chk (.*);

// *** dv/tb_top.sv ***
// bench for the port block: pin model, queued checks
`timescale 1ns/100ps
module tb_top;
  logic mclk_i = 0, rst_n_i = 0, dir_wr_i = 0, latch_wr_i = 0, port_wr_i = 0, ansel_wr_i = 0, od_wr_i = 0;
  logic [7:0] dir_wdata_i = 8'hFF, data_wdata_i = 8'h00, ext_val = 8'hFF, pad_i, pad_o, pad_oe_o;
  logic [7:0] pin_direction_o, output_latch_o, pin_level_o;
  logic [4:0] ansel_wdata_i = 5'h00, analog_select_o;
  logic [1:0] od_sel_i = 2'h0, od_wdata_i = 2'h0;
  logic [23:0] peripheral_pin_remap_i = 24'h000000;
  logic [5:0] periph_out_i = 6'h00, periph_en_i = 6'h00, open_drain_control_o;
  logic [31:0] lfsr = 32'h83BDEAF3;
  int err_count = 0, samples_checked = 0, cyc = 0, k;
  typedef struct {int due, sel; logic [7:0] exp;} note_t;
  note_t q[$];
  logic [5:0] od_exp = 6'h00;
  wire [47:0] seen = {2'h0, open_drain_control_o, pad_o & pad_oe_o, pad_oe_o, pin_level_o, output_latch_o,
                      pin_direction_o};
  gpio_port DUT (.*);
  gpio_pins_model pins (.*);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [7:0] got, exp);
    samples_checked++;
    err_count += got !== exp;
    if (got !== exp) $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic note(input int s, input logic [7:0] e);
    q.push_back('{cyc + 4, s, e});
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always #20 mclk_i = ~mclk_i;
  // notes fall due on falling edges, well after the outputs settle
  always @(negedge mclk_i)
  begin
    cyc++;
    while (q.size() > 0 && q[0].due <= cyc)
    begin
      check(seen[8 * q[0].sel +: 8], q[0].exp);
      void'(q.pop_front());
    end
    if (cyc > 1000)
    begin
      err_count++;
      print_verdict();
    end
  end
  // random loads, then each open-drain unit on its own remapped pin
  initial
  begin
    step(12);
    rst_n_i = 1;
    for (k = 0; k < 8; k++)
    begin
      lfsr = nxt(lfsr);
      {ext_val, data_wdata_i, dir_wdata_i} = lfsr[23:0];
      ansel_wdata_i = k == 7 ? 5'h1F : lfsr[28:24];
      {dir_wr_i, ansel_wr_i, latch_wr_i, port_wr_i} = {2'h3, k[0], !k[0]};
      step(1);
      {dir_wr_i, ansel_wr_i, latch_wr_i, port_wr_i} = 4'h0;
      step(6);
      note(1, data_wdata_i);
      note(3, ~dir_wdata_i);
      note(4, data_wdata_i & ~dir_wdata_i);
      note(2, {3'h7, ansel_wdata_i} & (~dir_wdata_i & data_wdata_i | dir_wdata_i & ext_val));
      step(5);
    end
    dir_wdata_i = 8'hFF;
    dir_wr_i = 1;
    step(1);
    dir_wr_i = 0;
    for (k = 0; k < 6; k++)
    begin
      peripheral_pin_remap_i = 24'(k + 1) << 3 * k;
      periph_en_i = 6'(1 << k);
      periph_out_i = 6'h3F;
      od_sel_i = 2'((k / 2 + 1) % 3);
      step(2);
      note(3, 8'(1 << k));
      step(5);
      od_wdata_i = 2'(1 << k % 2);
      od_wr_i = 1;
      od_exp[2 * od_sel_i +: 2] = od_wdata_i;
      step(1);
      od_wr_i = 0;
      note(3, 8'h00);
      note(5, {2'h0, od_exp});
      step(5);
      periph_out_i = 6'h00;
      note(3, 8'(1 << k));
      note(4, 8'h00);
      step(5);
    end
    print_verdict();
  end
endmodule
